// *** src/ahc_params.svh ***
`ifndef AHC_PARAMS_SVH
`define AHC_PARAMS_SVH
`define AHC_CLK_HZ 64'd10000000
`define AHC_SEC_PER_MIN 64'd60
`define AHC_MS_PER_S 64'd1000
`define AHC_PCT_STEPS 64'd100
`define AHC_SAVE_MIN_S 64'd6
`define AHC_SAVE_MAX_S 64'd9
`define AHC_RAMP_COOL_S 64'd30
`define AHC_RAMP_ELEC_S 64'd15
`define AHC_HUMID_LOW_MIN 64'd2
`define AHC_HUMID_MID_MIN 64'd5
`define AHC_DRY_TAIL_S 64'd60
`define AHC_TEMP_LEAD_S 64'd90
`define AHC_TEMP_TAIL_S 64'd30
`define AHC_DIGIT_MS 64'd1000
`define AHC_PCT_W 7
`define AHC_PCT_ZERO 7'h00
`define AHC_PCT_HALF 7'h32
`define AHC_PCT_HUMID_MID 7'h52
`define AHC_PCT_TEMPERATE 7'h3F
`define AHC_PCT_FULL 7'h64
`define AHC_PCT_IDLE_0 7'h28
`define AHC_PCT_IDLE_1 7'h3C
`define AHC_PCT_IDLE_2 7'h50
`define AHC_PCT_IDLE_3 7'h64
`define AHC_AUX_W 6
`define AHC_AF_W 8
`define AHC_SYS_W 5
`define AHC_MODEL_W 6
`define AHC_MODEL_RST 6'h00
`define AHC_AF_HEAT_HI 1
`define AHC_AF_HEAT_LO 0
`define AHC_AF_LOW_HI 4
`define AHC_AF_LOW_LO 2
`define AHC_AF_HIGH_HI 7
`define AHC_AF_HIGH_LO 5
`define AHC_AUX_S1_HI 1
`define AHC_AUX_S1_LO 0
`define AHC_AUX_KIT_HI 5
`define AHC_AUX_KIT_LO 2
`define AHC_SYS_EQUIP 0
`define AHC_SYS_COMFORT_HI 2
`define AHC_SYS_COMFORT_LO 1
`define AHC_SYS_IDLE_HI 4
`define AHC_SYS_IDLE_LO 3
`define AHC_S1_HT_B 2'h2
`define AHC_S1_BOTH 2'h3
`define AHC_FD_COND 8'h24
`define AHC_FD_TLOW 8'h37
`define AHC_FD_ROTOR 8'h38
`define AHC_FD_PARAM 8'h39
`define AHC_FD_BADTIME 8'h40
`define AHC_FD_LIMIT 8'h41
`define AHC_FD_NONE 8'h00
`endif

// *** src/ahc_pkg.sv ***
`include "ahc_params.svh"
package ahc_pkg;
  typedef struct packed {
    logic first_stage_heat_call;
    logic second_stage_heat_call;
    logic pump_heat_call;
    logic chill_call;
    logic fan_call;
  } ahc_calls_t;
  typedef struct packed {
    logic temp_low;
    logic lost_rotor;
    logic param_incomplete;
    logic param_bad_time;
    logic fault_limit;
  } ahc_motor_flt_t;
  typedef struct packed {
    logic [3:0] first;
    logic [3:0] second;
  } ahc_digits_t;
  typedef enum logic {AHC_EQ_HEAT_PUMP, AHC_EQ_AIR_COND} ahc_equip_t;
  typedef enum logic [1:0] {AHC_CF_NORMAL, AHC_CF_HUMID, AHC_CF_DRY, AHC_CF_TEMPERATE} ahc_comfort_t;
  typedef enum logic [2:0] {AHC_CS_IDLE, AHC_CS_STEP1, AHC_CS_STEP2, AHC_CS_FULL, AHC_CS_TAIL} ahc_chill_st_t;
  typedef enum logic [2:0] {
    AHC_FS_NONE, AHC_FS_COND, AHC_FS_TLOW, AHC_FS_ROTOR, AHC_FS_PARAM, AHC_FS_BADTIME, AHC_FS_LIMIT
  } ahc_fault_src_t;
endpackage : ahc_pkg

// *** src/ahc_ramp.sv ***
`timescale 1ns/1ps
`include "ahc_params.svh"
module ahc_ramp #(
  parameter int LW = `AHC_PCT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Requested level and pace
  input wire logic [LW-1:0] target,
  input wire logic [31:0] step_cycles,
  // Present level
  output logic [LW-1:0] level
);
  logic [LW-1:0] level_ff;
  logic [31:0] pace_ff;

  // One percent per step keeps a full-scale swing inside the allowed ramp time.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_ff <= '0;
      pace_ff <= 32'h0;
    end else if (level_ff == target) begin
      pace_ff <= 32'h0;
    end else if (pace_ff + 32'h1 >= step_cycles) begin
      pace_ff <= 32'h0;
      level_ff <= (level_ff < target) ? level_ff + LW'(1) : level_ff - LW'(1);
    end else begin
      pace_ff <= pace_ff + 32'h1;
    end
  end

  assign level = level_ff;

  AST_RAMP_SLOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    (level_ff != $past(level_ff)) |=> (level_ff == $past(level_ff)) || (step_cycles <= 32'h1))
    else $error("Blower level moved on two cycles in a row.");
endmodule : ahc_ramp

// *** src/ahc_core.sv ***
`timescale 1ns/1ps
`include "ahc_params.svh"
// Overview of operation
// - Humidifier drive on during any heating call except a pump call in air conditioner mode.
// - Stage one to relay A, two to B.
// - Size setting 00/01 maps stage one to A.
// - Size 10 maps to B, 11 both.
// - Electric heat plus cool: code 24, lockout, outputs off.
// - Button held 6 to 9 s stores model.
// - No model save while any call active.
// - Low chill airflow switches 3-5, high 6-8.
// - Equipment switch 0 heat pump, 1 air conditioner.
// - Fan-only airflow 40, 60, 80, 100 percent.
// - Heat kit code from two banks, six bits.
// - Blower ramps gradually, cooling within 30 s.
// - Electric heat ramps within 15 s.
// - Comfort setting normal, humid, dry, temperate.
// - Normal profile ramps straight zero to full.
// - Motor temperature low shows 3 then 7.
// - Lost rotor shows 3 then 8.
// - Incomplete motor parameters show 3 then 9.
// - Badly timed parameter change shows 4 then 0.
// - Motor fault limit shows 4 1, blower locked.
// - Humid: 50% 2 min, 82% 5 min, full.
// - Dry: 50% for 60 s after cooling.
// - Temperate: 63% for 90 s, then full.
// - Temperate: 63% for 30 s after cooling.
module ahc_core import ahc_pkg::*; #(
  parameter logic [31:0] SAVE_MIN_CYC = 32'(`AHC_SAVE_MIN_S * `AHC_CLK_HZ),
  parameter logic [31:0] SAVE_MAX_CYC = 32'(`AHC_SAVE_MAX_S * `AHC_CLK_HZ),
  parameter logic [31:0] RAMP_COOL_STEP = 32'(`AHC_RAMP_COOL_S * `AHC_CLK_HZ / `AHC_PCT_STEPS),
  parameter logic [31:0] RAMP_ELEC_STEP = 32'(`AHC_RAMP_ELEC_S * `AHC_CLK_HZ / `AHC_PCT_STEPS),
  parameter logic [31:0] HUMID_LOW_CYC = 32'(`AHC_HUMID_LOW_MIN * `AHC_SEC_PER_MIN * `AHC_CLK_HZ),
  parameter logic [31:0] HUMID_MID_CYC = 32'(`AHC_HUMID_MID_MIN * `AHC_SEC_PER_MIN * `AHC_CLK_HZ),
  parameter logic [31:0] DRY_TAIL_CYC = 32'(`AHC_DRY_TAIL_S * `AHC_CLK_HZ),
  parameter logic [31:0] TEMP_LEAD_CYC = 32'(`AHC_TEMP_LEAD_S * `AHC_CLK_HZ),
  parameter logic [31:0] TEMP_TAIL_CYC = 32'(`AHC_TEMP_TAIL_S * `AHC_CLK_HZ),
  parameter logic [31:0] DIGIT_CYC = 32'(`AHC_DIGIT_MS * `AHC_CLK_HZ / `AHC_MS_PER_S)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Thermostat calls and push button
  input wire ahc_calls_t tstat_calls,
  input wire logic save_button,
  // Installer switch banks
  input wire logic [`AHC_AUX_W-1:0] aux_switch_bank,
  input wire logic [`AHC_AF_W-1:0] airflow_switch_bank,
  input wire logic [`AHC_SYS_W-1:0] system_switch_bank,
  input wire logic [`AHC_MODEL_W-1:0] model_switches,
  // Motor fault reports
  input wire ahc_motor_flt_t motor_faults,
  // Relay and humidifier drives
  output logic heater_relay_a,
  output logic heater_relay_b,
  output logic humidifier_drive,
  // Blower requests
  output logic [`AHC_PCT_W-1:0] blower_level,
  output logic [2:0] first_stage_chill_airflow_sel,
  output logic [2:0] second_stage_chill_airflow_sel,
  output logic [5:0] heat_kit_airflow_code,
  output ahc_equip_t equipment_type_select,
  output ahc_comfort_t comfort_profile,
  output logic [1:0] idle_blower_level,
  // Model configuration
  output logic [`AHC_MODEL_W-1:0] model_config,
  output logic model_saved,
  // Status
  output logic conflict_lockout,
  output logic blower_lockout,
  output ahc_digits_t fault_digits,
  output logic [3:0] display_digit,
  output logic display_second
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  localparam int SYNC_W = $bits(ahc_calls_t) + 1 + `AHC_AUX_W + `AHC_AF_W + `AHC_SYS_W + `AHC_MODEL_W
    + $bits(ahc_motor_flt_t);

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  ahc_calls_t calls;
  logic button;
  logic [`AHC_AUX_W-1:0] aux_sw;
  logic [`AHC_AF_W-1:0] af_sw;
  logic [`AHC_SYS_W-1:0] sys_sw;
  logic [`AHC_MODEL_W-1:0] model_sw;
  ahc_motor_flt_t mflt;

  // Every pin is a switch or a slow 24 V level, so a plain two-stage synchroniser is enough.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {tstat_calls, save_button, aux_switch_bank, airflow_switch_bank, system_switch_bank,
                  model_switches, motor_faults};
      sync_ff <= meta_ff;
    end
  end

  assign {calls, button, aux_sw, af_sw, sys_sw, model_sw, mflt} = sync_ff;

  ahc_equip_t equip;
  ahc_comfort_t comfort;
  logic [1:0] s1_size;
  logic elec_heat;
  logic pump_heat;
  logic heat_any;
  logic any_call;
  logic conflict;
  logic lock_now;

  assign equip = ahc_equip_t'(sys_sw[`AHC_SYS_EQUIP]);
  assign comfort = ahc_comfort_t'(sys_sw[`AHC_SYS_COMFORT_HI:`AHC_SYS_COMFORT_LO]);
  assign s1_size = aux_sw[`AHC_AUX_S1_HI:`AHC_AUX_S1_LO];
  assign elec_heat = calls.first_stage_heat_call | calls.second_stage_heat_call;
  assign pump_heat = calls.pump_heat_call & (equip == AHC_EQ_HEAT_PUMP);
  assign heat_any = elec_heat | pump_heat;
  assign any_call = |calls;
  assign conflict = elec_heat & calls.chill_call;
  assign lock_now = conflict | conflict_lockout;

  assign first_stage_chill_airflow_sel = af_sw[`AHC_AF_LOW_HI:`AHC_AF_LOW_LO];
  assign second_stage_chill_airflow_sel = af_sw[`AHC_AF_HIGH_HI:`AHC_AF_HIGH_LO];
  assign heat_kit_airflow_code = {af_sw[`AHC_AF_HEAT_HI:`AHC_AF_HEAT_LO],
                                  aux_sw[`AHC_AUX_KIT_HI:`AHC_AUX_KIT_LO]};
  assign equipment_type_select = equip;
  assign comfort_profile = comfort;
  assign idle_blower_level = sys_sw[`AHC_SYS_IDLE_HI:`AHC_SYS_IDLE_LO];

  logic conflict_lockout_ff;
  logic blower_lockout_ff;
  logic relay_a_ff;
  logic relay_b_ff;
  logic humid_ff;

  // Both lockouts hold until power is cycled; nothing but reset clears them.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conflict_lockout_ff <= 1'b0;
      blower_lockout_ff <= 1'b0;
    end else begin
      if (conflict) conflict_lockout_ff <= 1'b1;
      if (mflt.fault_limit) blower_lockout_ff <= 1'b1;
    end
  end

  assign conflict_lockout = conflict_lockout_ff;
  assign blower_lockout = blower_lockout_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      relay_a_ff <= 1'b0;
      relay_b_ff <= 1'b0;
      humid_ff <= 1'b0;
    end else begin
      relay_a_ff <= !lock_now && calls.first_stage_heat_call && (s1_size != `AHC_S1_HT_B);
      relay_b_ff <= !lock_now && (calls.second_stage_heat_call || (calls.first_stage_heat_call
                    && (s1_size == `AHC_S1_HT_B || s1_size == `AHC_S1_BOTH)));
      humid_ff <= !lock_now && heat_any;
    end
  end

  assign heater_relay_a = relay_a_ff;
  assign heater_relay_b = relay_b_ff;
  assign humidifier_drive = humid_ff;

  ahc_chill_st_t st_ff;
  logic [31:0] tmr_ff;
  logic chill_on;
  logic [31:0] lead_len;
  logic [31:0] tail_len;
  logic wants_tail;

  assign chill_on = calls.chill_call && !lock_now && !blower_lockout_ff;
  assign lead_len = (comfort == AHC_CF_HUMID) ? HUMID_LOW_CYC : TEMP_LEAD_CYC;
  assign tail_len = (comfort == AHC_CF_DRY) ? DRY_TAIL_CYC : TEMP_TAIL_CYC;
  assign wants_tail = (comfort == AHC_CF_DRY || comfort == AHC_CF_TEMPERATE) && !lock_now && !blower_lockout_ff;

  // Hold times run from the entry of a step, so the ramp into a level is part of its hold.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= AHC_CS_IDLE;
      tmr_ff <= 32'h0;
    end else begin
      tmr_ff <= tmr_ff + 32'h1;
      case (st_ff)
        AHC_CS_IDLE: begin
          tmr_ff <= 32'h0;
          if (chill_on) begin
            st_ff <= (comfort == AHC_CF_HUMID || comfort == AHC_CF_TEMPERATE) ? AHC_CS_STEP1
                     : AHC_CS_FULL;
          end
        end
        AHC_CS_STEP1: begin
          if (!chill_on) begin
            st_ff <= wants_tail ? AHC_CS_TAIL : AHC_CS_IDLE;
            tmr_ff <= 32'h0;
          end else if (tmr_ff + 32'h1 >= lead_len) begin
            st_ff <= (comfort == AHC_CF_HUMID) ? AHC_CS_STEP2 : AHC_CS_FULL;
            tmr_ff <= 32'h0;
          end
        end
        AHC_CS_STEP2: begin
          if (!chill_on) begin
            st_ff <= wants_tail ? AHC_CS_TAIL : AHC_CS_IDLE;
            tmr_ff <= 32'h0;
          end else if (tmr_ff + 32'h1 >= HUMID_MID_CYC) begin
            st_ff <= AHC_CS_FULL;
            tmr_ff <= 32'h0;
          end
        end
        AHC_CS_FULL: begin
          tmr_ff <= 32'h0;
          if (!chill_on) st_ff <= wants_tail ? AHC_CS_TAIL : AHC_CS_IDLE;
        end
        AHC_CS_TAIL: begin
          if (chill_on || !wants_tail || tmr_ff + 32'h1 >= tail_len) begin
            st_ff <= AHC_CS_IDLE;
            tmr_ff <= 32'h0;
          end
        end
        default: st_ff <= AHC_CS_IDLE;
      endcase
    end
  end

  logic [`AHC_PCT_W-1:0] chill_pct;
  logic [`AHC_PCT_W-1:0] idle_pct;
  logic [`AHC_PCT_W-1:0] target;

  always_comb begin
    case (st_ff)
      AHC_CS_STEP1: chill_pct = (comfort == AHC_CF_HUMID) ? `AHC_PCT_HALF : `AHC_PCT_TEMPERATE;
      AHC_CS_STEP2: chill_pct = `AHC_PCT_HUMID_MID;
      AHC_CS_FULL: chill_pct = `AHC_PCT_FULL;
      AHC_CS_TAIL: chill_pct = (comfort == AHC_CF_DRY) ? `AHC_PCT_HALF : `AHC_PCT_TEMPERATE;
      default: chill_pct = `AHC_PCT_ZERO;
    endcase
    case (idle_blower_level)
      2'h0: idle_pct = `AHC_PCT_IDLE_0;
      2'h1: idle_pct = `AHC_PCT_IDLE_1;
      2'h2: idle_pct = `AHC_PCT_IDLE_2;
      default: idle_pct = `AHC_PCT_IDLE_3;
    endcase
    if (lock_now || blower_lockout_ff) target = `AHC_PCT_ZERO;
    else if (heat_any) target = `AHC_PCT_FULL;
    else if (st_ff != AHC_CS_IDLE) target = chill_pct;
    else if (calls.fan_call) target = idle_pct;
    else target = `AHC_PCT_ZERO;
  end

  ahc_ramp #(
    .LW(`AHC_PCT_W)
  ) u_ramp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .target(target),
    .step_cycles(elec_heat ? RAMP_ELEC_STEP : RAMP_COOL_STEP),
    .level(blower_level)
  );

  logic [31:0] btn_cnt_ff;
  logic btn_call_ff;
  logic [`AHC_MODEL_W-1:0] model_ff;
  logic saved_ff;
  logic btn_release;

  assign btn_release = !button && (btn_cnt_ff != 32'h0);

  // The count saturates just past the window, so an over-long hold can never wrap back into it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      btn_cnt_ff <= 32'h0;
      btn_call_ff <= 1'b0;
      model_ff <= `AHC_MODEL_RST;
      saved_ff <= 1'b0;
    end else begin
      saved_ff <= 1'b0;
      if (button) begin
        if (btn_cnt_ff <= SAVE_MAX_CYC) btn_cnt_ff <= btn_cnt_ff + 32'h1;
        if (any_call) btn_call_ff <= 1'b1;
      end else begin
        btn_cnt_ff <= 32'h0;
        btn_call_ff <= 1'b0;
      end
      if (btn_release && btn_cnt_ff >= SAVE_MIN_CYC && btn_cnt_ff <= SAVE_MAX_CYC
          && !btn_call_ff && !any_call) begin
        model_ff <= model_sw;
        saved_ff <= 1'b1;
      end
    end
  end

  assign model_config = model_ff;
  assign model_saved = saved_ff;

  ahc_motor_flt_t mflt_prev_ff;
  ahc_fault_src_t src_ff;
  ahc_fault_src_t nxt_src;
  logic src_alive;
  logic [7:0] nxt_code;
  ahc_digits_t digits_ff;

  always_comb begin
    case (src_ff)
      AHC_FS_COND: src_alive = conflict_lockout_ff;
      AHC_FS_TLOW: src_alive = mflt.temp_low;
      AHC_FS_ROTOR: src_alive = mflt.lost_rotor;
      AHC_FS_PARAM: src_alive = mflt.param_incomplete;
      AHC_FS_BADTIME: src_alive = mflt.param_bad_time;
      AHC_FS_LIMIT: src_alive = blower_lockout_ff;
      default: src_alive = 1'b0;
    endcase
    // Newest event wins; among simultaneous ones the most severe is shown.
    if (mflt.fault_limit && !mflt_prev_ff.fault_limit) nxt_src = AHC_FS_LIMIT;
    else if (mflt.param_bad_time && !mflt_prev_ff.param_bad_time) nxt_src = AHC_FS_BADTIME;
    else if (mflt.param_incomplete && !mflt_prev_ff.param_incomplete) nxt_src = AHC_FS_PARAM;
    else if (mflt.lost_rotor && !mflt_prev_ff.lost_rotor) nxt_src = AHC_FS_ROTOR;
    else if (mflt.temp_low && !mflt_prev_ff.temp_low) nxt_src = AHC_FS_TLOW;
    else if (conflict && !conflict_lockout_ff) nxt_src = AHC_FS_COND;
    else if (src_alive) nxt_src = src_ff;
    else nxt_src = AHC_FS_NONE;
    case (nxt_src)
      AHC_FS_COND: nxt_code = `AHC_FD_COND;
      AHC_FS_TLOW: nxt_code = `AHC_FD_TLOW;
      AHC_FS_ROTOR: nxt_code = `AHC_FD_ROTOR;
      AHC_FS_PARAM: nxt_code = `AHC_FD_PARAM;
      AHC_FS_BADTIME: nxt_code = `AHC_FD_BADTIME;
      AHC_FS_LIMIT: nxt_code = `AHC_FD_LIMIT;
      default: nxt_code = `AHC_FD_NONE;
    endcase
  end

  logic [31:0] dig_tmr_ff;
  logic show_second_ff;
  logic [3:0] disp_ff;
  logic nxt_show;

  assign nxt_show = (nxt_src != src_ff) ? 1'b0
                  : ((dig_tmr_ff + 32'h1 >= DIGIT_CYC) ? !show_second_ff : show_second_ff);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mflt_prev_ff <= '0;
      src_ff <= AHC_FS_NONE;
      digits_ff <= '0;
      dig_tmr_ff <= 32'h0;
      show_second_ff <= 1'b0;
      disp_ff <= 4'h0;
    end else begin
      mflt_prev_ff <= mflt;
      src_ff <= nxt_src;
      digits_ff <= nxt_code;
      dig_tmr_ff <= (nxt_src != src_ff || dig_tmr_ff + 32'h1 >= DIGIT_CYC) ? 32'h0 : dig_tmr_ff + 32'h1;
      show_second_ff <= nxt_show;
      disp_ff <= nxt_show ? nxt_code[3:0] : nxt_code[7:4];
    end
  end

  assign fault_digits = digits_ff;
  assign display_digit = disp_ff;
  assign display_second = show_second_ff;

  AST_HUMID_ON: assert property ((heat_any && !lock_now) |=> humid_ff)
    else $error("Humidifier not driven during a heating call.");
  AST_STAGE_TWO: assert property ((calls.second_stage_heat_call && !lock_now) |=> relay_b_ff)
    else $error("Relay B not driven for a second stage call.");
  AST_SIZE_LOW: assert property ((calls.first_stage_heat_call && !calls.second_stage_heat_call && !lock_now
    && s1_size[1] == 1'b0) |=> (relay_a_ff && !relay_b_ff))
    else $error("Stage one did not map to relay A alone.");
  AST_SIZE_HIGH: assert property ((calls.first_stage_heat_call && !calls.second_stage_heat_call && !lock_now
    && s1_size[1]) |=> (relay_b_ff && relay_a_ff == $past(s1_size[0])))
    else $error("Stage one relay mapping wrong for sizes 10 or 11.");
  AST_CONFLICT_LOCK: assert property (conflict |=> (conflict_lockout_ff && !relay_a_ff && !relay_b_ff && !humid_ff)
    ##1 conflict_lockout_ff)
    else $error("Heat and cool together did not lock out.");
  AST_SAVE_WINDOW: assert property (saved_ff |-> ($past(btn_cnt_ff) >= SAVE_MIN_CYC
    && $past(btn_cnt_ff) <= SAVE_MAX_CYC && model_ff == $past(model_sw, 1)))
    else $error("Model stored outside the hold window.");
  AST_SAVE_NO_CALL: assert property (saved_ff |-> !$past(any_call) && !$past(btn_call_ff))
    else $error("Model stored while a thermostat call was active.");
  AST_FAN_ONLY: assert property ((calls.fan_call && !heat_any && st_ff == AHC_CS_IDLE && !lock_now
    && !blower_lockout_ff && idle_blower_level == 2'h1) |-> target == `AHC_PCT_IDLE_1)
    else $error("Fan-only airflow does not match its setting.");
  AST_HUMID_STEP: assert property ((st_ff == AHC_CS_STEP1 && comfort == AHC_CF_HUMID && chill_on && !heat_any)
    |-> target == `AHC_PCT_HALF)
    else $error("Humid profile first step not at half capacity.");
  AST_LIMIT_LOCK: assert property ((mflt.fault_limit && !mflt_prev_ff.fault_limit) |=>
    (digits_ff == `AHC_FD_LIMIT && blower_lockout_ff) ##1 (target == `AHC_PCT_ZERO))
    else $error("Fault limit did not show 4 1 or lock the blower.");
  AST_ROTOR_CODE: assert property ((mflt.lost_rotor && !mflt_prev_ff.lost_rotor && !mflt.fault_limit
    && !mflt.param_bad_time && !mflt.param_incomplete) |=> digits_ff == `AHC_FD_ROTOR)
    else $error("Lost rotor not shown as 3 8.");
endmodule : ahc_core

// *** tb/ahc_far.sv ***
`timescale 1ns/1ps
// Thermostat call and motor fault lines, which change just after a rising edge and then hold.
module ahc_far import ahc_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Pins into the board
  output ahc_calls_t tstat_calls,
  output ahc_motor_flt_t motor_faults
);
  initial begin
    tstat_calls = '0;
    motor_faults = '0;
  end
  task automatic set_calls(input ahc_calls_t c);
    @(posedge clk_sys);
    #1;
    tstat_calls = c;
  endtask : set_calls
  task automatic set_faults(input ahc_motor_flt_t f);
    @(posedge clk_sys);
    #1;
    motor_faults = f;
  endtask : set_faults
endmodule : ahc_far

// *** tb/ahc_core_bench.sv ***
`timescale 1ns/1ps
module ahc_core_bench import ahc_pkg::*; ;
  logic clk_sys, rstn, btn, ra, rb, hum, saved, c_lock, b_lock, d_sec;
  logic [5:0] aux, msw, kit, cfg;
  logic [7:0] af;
  logic [4:0] sys;
  logic [6:0] lvl;
  logic [2:0] lo, hi;
  logic [1:0] idle;
  logic [3:0] dd;
  ahc_calls_t calls;
  ahc_motor_flt_t flt;
  ahc_equip_t eq;
  ahc_comfort_t cf;
  ahc_digits_t fd;
  int n_fail = 0;
  int checks = 0;
  ahc_far u_ahc_far (.clk_sys(clk_sys), .tstat_calls(calls), .motor_faults(flt));
  // Short counts keep the run brief; every bound below is scaled from them.
  ahc_core #(.SAVE_MIN_CYC(32'h3C), .SAVE_MAX_CYC(32'h5A), .RAMP_COOL_STEP(32'h3), .RAMP_ELEC_STEP(32'h2),
    .HUMID_LOW_CYC(32'hC8), .HUMID_MID_CYC(32'h96), .DRY_TAIL_CYC(32'hC8), .TEMP_LEAD_CYC(32'hFA),
    .TEMP_TAIL_CYC(32'hA0), .DIGIT_CYC(32'h8)) u_ahc_core (
    .clk_sys(clk_sys), .rstn(rstn), .tstat_calls(calls), .save_button(btn), .aux_switch_bank(aux),
    .airflow_switch_bank(af), .system_switch_bank(sys), .model_switches(msw), .motor_faults(flt),
    .heater_relay_a(ra), .heater_relay_b(rb), .humidifier_drive(hum), .blower_level(lvl),
    .first_stage_chill_airflow_sel(lo), .second_stage_chill_airflow_sel(hi), .heat_kit_airflow_code(kit),
    .equipment_type_select(eq), .comfort_profile(cf), .idle_blower_level(idle), .model_config(cfg),
    .model_saved(saved), .conflict_lockout(c_lock), .blower_lockout(b_lock), .fault_digits(fd),
    .display_digit(dd), .display_second(d_sec));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_lvl(input logic [6:0] want, input int bound);
    for (int k = 0; k < bound && lvl !== want; k++) tick(1);
  endtask : wait_lvl
  task automatic do_reset;
    rstn = 1'b0;
    tick(6);
    rstn = 1'b1;
    tick(2);
  endtask : do_reset
  task automatic t_decode;
    logic [7:0] afp [2] = '{8'h57, 8'hA8};
    logic [5:0] axp [2] = '{6'h24, 6'h18};
    for (int i = 0; i < 2; i++) begin
      af = afp[i];
      aux = axp[i];
      tick(4);
      chk(8'({lo, hi}), {2'h0, afp[i][4:2], afp[i][7:5]});
      chk(8'(kit), 8'({afp[i][1:0], axp[i][5:2]}));
    end
  endtask : t_decode
  task automatic t_heat;
    logic [4:0] cl [8] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h18, 5'h08, 5'h04, 5'h04};
    logic [2:0] ex [8] = '{3'h5, 3'h5, 3'h3, 3'h7, 3'h7, 3'h3, 3'h1, 3'h0};
    // Bank bit one is the high bit of the size field; the last step repeats the pump call in air conditioner mode.
    for (int i = 0; i < 8; i++) begin
      aux = (i < 4) ? {4'h0, i[1:0]} : 6'h03;
      sys = (i == 7) ? 5'h01 : 5'h00;
      u_ahc_far.set_calls(cl[i]);
      tick(4);
      chk(8'({ra, rb, hum}), 8'(ex[i]));
    end
    u_ahc_far.set_calls(5'h00);
  endtask : t_heat
  task automatic t_ramp;
    wait_lvl(7'h00, 400);
    for (int i = 0; i < 2; i++) begin
      u_ahc_far.set_calls(i ? 5'h02 : 5'h10);
      wait_lvl(7'h64, i ? 320 : 220);
      chk(8'(lvl), 8'h64);
      u_ahc_far.set_calls(5'h00);
      wait_lvl(7'h00, 320);
      chk(8'(lvl), 8'h00);
    end
  endtask : t_ramp
  task automatic t_fan;
    logic [6:0] pct [4] = '{7'h28, 7'h3C, 7'h50, 7'h64};
    for (int c = 0; c < 4; c++) begin
      sys = {c[1], c[0], c[1], c[0], c[0]};
      tick(4);
      chk({3'h0, cf, idle, eq}, 8'({c[1:0], c[1:0], c[0]}));
      u_ahc_far.set_calls(5'h01);
      wait_lvl(pct[c], 3 * pct[c] + 20);
      chk(8'(lvl), 8'(pct[c]));
      u_ahc_far.set_calls(5'h00);
      wait_lvl(7'h00, 320);
    end
  endtask : t_fan
  task automatic hold_lvl(input logic [6:0] want, input int bound);
    wait_lvl(want, bound);
    chk(8'(lvl), 8'(want));
    // Thirty cycles later the profile must still be resting at this level.
    tick(30);
    chk(8'(lvl), 8'(want));
  endtask : hold_lvl
  task automatic t_profile;
    sys = 5'h02;
    u_ahc_far.set_calls(5'h02);
    hold_lvl(7'h32, 170);
    hold_lvl(7'h52, 150);
    wait_lvl(7'h64, 120);
    chk(8'(lvl), 8'h64);
    u_ahc_far.set_calls(5'h00);
    wait_lvl(7'h00, 320);
    sys = 5'h04;
    u_ahc_far.set_calls(5'h02);
    wait_lvl(7'h64, 320);
    chk(8'(lvl), 8'h64);
    u_ahc_far.set_calls(5'h00);
    hold_lvl(7'h32, 170);
    wait_lvl(7'h00, 200);
    chk(8'(lvl), 8'h00);
    sys = 5'h06;
    u_ahc_far.set_calls(5'h02);
    hold_lvl(7'h3F, 210);
    wait_lvl(7'h64, 160);
    chk(8'(lvl), 8'h64);
    u_ahc_far.set_calls(5'h00);
    hold_lvl(7'h3F, 130);
    wait_lvl(7'h00, 230);
    chk(8'(lvl), 8'h00);
  endtask : t_profile
  task automatic t_faults;
    logic [4:0] src [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    logic [7:0] code [5] = '{8'h37, 8'h38, 8'h39, 8'h40, 8'h41};
    for (int i = 0; i < 5; i++) begin
      u_ahc_far.set_faults(src[i]);
      tick(5);
      chk(fd, code[i]);
      chk(8'({d_sec, dd}), 8'({1'b0, code[i][7:4]}));
      tick(10);
      chk(8'({d_sec, dd}), 8'({1'b1, code[i][3:0]}));
      u_ahc_far.set_faults(5'h00);
      tick(5);
      chk(fd, (i == 4) ? 8'h41 : 8'h00);
    end
    chk(8'(b_lock), 8'h01);
    do_reset();
  endtask : t_faults
  task automatic t_conflict;
    u_ahc_far.set_calls(5'h12);
    tick(5);
    chk(8'({c_lock, ra, rb, hum}), 8'h08);
    chk(fd, 8'h24);
    // Dropping the cool call must not release the lockout.
    u_ahc_far.set_calls(5'h10);
    tick(5);
    chk(8'({c_lock, ra, rb, hum}), 8'h08);
    u_ahc_far.set_calls(5'h00);
    do_reset();
  endtask : t_conflict
  task automatic t_save;
    int dur [4] = '{70, 30, 100, 70};
    chk(8'(cfg), 8'h00);
    for (int i = 0; i < 4; i++) begin
      msw = 6'h2D + 6'(i);
      if (i == 3) u_ahc_far.set_calls(5'h01);
      btn = 1'b1;
      tick(dur[i]);
      btn = 1'b0;
      for (int k = 0; k < 6 && saved !== 1'b1; k++) tick(1);
      chk(8'({saved, cfg}), {1'b0, i == 0, 6'h2D});
    end
    u_ahc_far.set_calls(5'h00);
  endtask : t_save
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    rstn = 1'b0;
    btn = 1'b0;
    af = 8'h00;
    aux = 6'h00;
    sys = 5'h00;
    msw = 6'h00;
    do_reset();
    t_decode();
    t_heat();
    t_ramp();
    t_fan();
    t_profile();
    t_faults();
    t_conflict();
    t_save();
    give_verdict();
  end
  // The whole sequence needs some 6000 cycles, so 20000 only trips on a real hang.
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule : ahc_core_bench
